// ==== hdl/osc_pkg.sv ====
// Purpose: constants for the oscillator select control block
// Assumes: one 8-bit control register on a plain strobe port
// Notes:   frequencies in kHz; the source encodings are local choices
package osc_pkg;
  localparam logic [1:0] REG_ADDR     = 2'h0;
  localparam logic [1:0] ADDR_CFG     = 2'h1;
  localparam int         BIT_SW_MULT  = 7;
  localparam int         FREQ_HI      = 6;
  localparam int         FREQ_LO      = 3;
  localparam int         BIT_UNIMPL   = 2;
  localparam int         SRC_HI       = 1;
  localparam int         SRC_LO       = 0;
  localparam logic [3:0] FREQ_RESET   = 4'h7;
  localparam logic [1:0] SRC_RESET    = 2'h0;
  localparam logic       SW_MULT_RST  = 1'b0;
  localparam logic [7:0] WRITE_MASK   = 8'hFB;
  typedef enum logic [2:0] {
    OSC_BAND_LF = 3'b001,
    OSC_BAND_MF = 3'b010,
    OSC_BAND_HF = 3'b100
  } osc_band_t;
  typedef enum logic [2:0] {
    OSC_SRC_CFG   = 3'b001,
    OSC_SRC_TIMER = 3'b010,
    OSC_SRC_INT   = 3'b100
  } osc_src_t;
  localparam logic [15:0] KHZ_LF     = 16'h001F;
  localparam logic [15:0] KHZ_MF_MIN = 16'h001F;
  localparam logic [15:0] KHZ_8M     = 16'h1F40;
  localparam logic [15:0] KHZ_32M    = 16'h7D00;
endpackage : osc_pkg

// ==== hdl/osc_freq_decode.sv ====
// Purpose: map frequency select code and multiplier state to band and rate
// Assumes: registered outputs, one cycle after the inputs change
// Notes:   31.25 kHz codes report 31 kHz since rate is whole kHz
module osc_freq_decode (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [3:0]        freq_sel,
  input  wire logic              mult_on,
  output osc_pkg::osc_band_t     band_q,
  output logic [15:0]            khz_q
);
  osc_pkg::osc_band_t band_d;
  logic [15:0]        khz_d;
  logic [15:0]        hf_khz;
  logic [15:0]        mf_khz;

  // high band: 125 kHz doubling from code 1000; 1110 gets 8 or 32 MHz
  assign hf_khz = (freq_sel == 4'hE) ? (mult_on ? osc_pkg::KHZ_32M : osc_pkg::KHZ_8M)
                                     : (16'h007D << freq_sel[2:0]);
  // mid band halves down from 500 kHz; 0011 duplicates 31.25 kHz from the high source
  // halving from 500 keeps 125 and 250 exact, where doubling 31 would drift low
  assign mf_khz = (freq_sel[2:0] <= 3'h3) ? osc_pkg::KHZ_MF_MIN
                                          : (16'h01F4 >> (3'h7 - freq_sel[2:0]));

  always_comb begin
    band_d = osc_pkg::OSC_BAND_LF;
    khz_d  = osc_pkg::KHZ_LF;
    if (freq_sel[3]) begin
      band_d = osc_pkg::OSC_BAND_HF;
      khz_d  = hf_khz;
    end else if (freq_sel[2:1] != 2'h0) begin
      band_d = (freq_sel == 4'h3) ? osc_pkg::OSC_BAND_HF : osc_pkg::OSC_BAND_MF;
      khz_d  = (freq_sel == 4'h7) ? 16'h01F4 : mf_khz;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      band_q <= osc_pkg::OSC_BAND_MF;
      khz_q  <= 16'h01F4;
    end else begin
      band_q <= band_d;
      khz_q  <= khz_d;
    end
  end
endmodule : osc_freq_decode

// ==== hdl/osc_select_ctrl.sv ====
// Purpose: oscillator control register and clock source selection
// Assumes: configuration fields are static inputs, synchronous to sys_clk
// Notes:   outputs are registered and follow a write by one or two cycles
//
// The address map and the plain strobed port were decided locally.
module osc_select_ctrl (
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire logic [1:0]     addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output logic [7:0]          rdata_q,
  input  wire logic           cfg_multiplier_force,
  input  wire logic [2:0]     cfg_osc_source_sel,
  output logic                times_four_multiplier_q,
  output osc_pkg::osc_src_t   src_q,
  output logic [2:0]          cfg_mode_q,
  output osc_pkg::osc_band_t  band_q,
  output logic [15:0]         khz_q
);
  logic                sw_multiplier_enable_q;
  logic [3:0]          int_osc_freq_sel_q;
  logic [1:0]          sys_clk_source_sel_q;
  logic [7:0]          reg_view;
  logic                reg_wr;
  logic                mult_d;
  osc_pkg::osc_src_t   src_d;
  logic [7:0]          rdata_d;

  assign reg_wr   = wr_en && (addr == osc_pkg::REG_ADDR);
  assign reg_view = {sw_multiplier_enable_q, int_osc_freq_sel_q, 1'b0,
                     sys_clk_source_sel_q};
  assign mult_d   = cfg_multiplier_force | sw_multiplier_enable_q;
  assign src_d    = sys_clk_source_sel_q[1] ? osc_pkg::OSC_SRC_INT
                  : sys_clk_source_sel_q[0] ? osc_pkg::OSC_SRC_TIMER
                  : osc_pkg::OSC_SRC_CFG;
  // unmapped reads return zero; config view at second address
  assign rdata_d  = !rd_en ? 8'h00
                  : (addr == osc_pkg::REG_ADDR) ? reg_view
                  : (addr == osc_pkg::ADDR_CFG) ? {4'h0, cfg_multiplier_force,
                                                   cfg_osc_source_sel}
                  : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_multiplier_enable_q <= osc_pkg::SW_MULT_RST;
      int_osc_freq_sel_q     <= osc_pkg::FREQ_RESET;
      sys_clk_source_sel_q   <= osc_pkg::SRC_RESET;
    end else if (reg_wr) begin
      sw_multiplier_enable_q <= wdata[osc_pkg::BIT_SW_MULT];
      int_osc_freq_sel_q     <= wdata[osc_pkg::FREQ_HI:osc_pkg::FREQ_LO];
      sys_clk_source_sel_q   <= wdata[osc_pkg::SRC_HI:osc_pkg::SRC_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q                 <= 8'h00;
      times_four_multiplier_q <= 1'b0;
      src_q                   <= osc_pkg::OSC_SRC_CFG;
      cfg_mode_q              <= 3'h0;
    end else begin
      rdata_q                 <= rdata_d;
      times_four_multiplier_q <= mult_d;
      src_q                   <= src_d;
      cfg_mode_q              <= cfg_osc_source_sel;
    end
  end

  osc_freq_decode u_freq (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .freq_sel (int_osc_freq_sel_q),
    .mult_on  (mult_d),
    .band_q   (band_q),
    .khz_q    (khz_q)
  );

  a_mult_force: assert property (@(posedge sys_clk) disable iff (reset)
    cfg_multiplier_force && $stable(cfg_multiplier_force) |=> times_four_multiplier_q)
    else $error("multiplier not forced on");
  a_mult_sw: assert property (@(posedge sys_clk) disable iff (reset)
    !cfg_multiplier_force ##1 !cfg_multiplier_force
      |-> times_four_multiplier_q == $past(sw_multiplier_enable_q))
    else $error("multiplier does not follow software bit");
  a_reset_freq: assert property (@(posedge sys_clk)
    $past(reset) |-> int_osc_freq_sel_q == 4'h7)
    else $error("frequency code wrong after reset");
  a_band_hf: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q[3] && $stable(int_osc_freq_sel_q) |=> band_q == osc_pkg::OSC_BAND_HF)
    else $error("high code not in high band");
  a_band_lf: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q[3:1] == 3'h0 && $stable(int_osc_freq_sel_q)
      |=> band_q == osc_pkg::OSC_BAND_LF && khz_q == 16'h001F)
    else $error("low code not in low band");
  a_code_e: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'hE && $stable(int_osc_freq_sel_q) && $stable(mult_d)
      |=> khz_q == (times_four_multiplier_q ? 16'h7D00 : 16'h1F40))
    else $error("code 1110 rate wrong");
  a_src_int: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && wdata[1] |=> ##1 src_q == osc_pkg::OSC_SRC_INT)
    else $error("internal source not selected");
  a_src_timer: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && wdata[1:0] == 2'h1 |=> ##1 src_q == osc_pkg::OSC_SRC_TIMER)
    else $error("timer source not selected");
  a_src_cfg: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && wdata[1:0] == 2'h0 |=> ##1 src_q == osc_pkg::OSC_SRC_CFG)
    else $error("configuration source not selected");
  a_bit2_zero: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == osc_pkg::REG_ADDR |=> rdata_q[2] == 1'b0)
    else $error("bit 2 read nonzero");

  // multiplier is on when the software bit or the force input is set, and off when neither is
  a_mult_off: assert property (@(posedge sys_clk) disable iff (reset)
    !cfg_multiplier_force && !sw_multiplier_enable_q |=> !times_four_multiplier_q)
    else $error("multiplier on without request");
  a_mult_sw_on: assert property (@(posedge sys_clk) disable iff (reset)
    sw_multiplier_enable_q |=> times_four_multiplier_q)
    else $error("multiplier off with software bit set");
  a_mult_rise: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(cfg_multiplier_force) |=> times_four_multiplier_q)
    else $error("multiplier not on after force rises");

  // reset state, seen both during reset and at the first edge after it
  a_reset_regs: assert property (@(posedge sys_clk)
    $past(reset) |-> reg_view == {osc_pkg::SW_MULT_RST, osc_pkg::FREQ_RESET, 1'b0,
                                  osc_pkg::SRC_RESET})
    else $error("control register wrong after reset");
  a_reset_outs: assert property (@(posedge sys_clk)
    $past(reset) |-> band_q == osc_pkg::OSC_BAND_MF && khz_q == 16'h01F4)
    else $error("rate outputs wrong after reset");
  a_reset_misc: assert property (@(posedge sys_clk)
    $past(reset) |-> !times_four_multiplier_q && rdata_q == 8'h00)
    else $error("multiplier or read data wrong after reset");
  a_reset_src: assert property (@(posedge sys_clk)
    $past(reset) |-> src_q == osc_pkg::OSC_SRC_CFG)
    else $error("source wrong after reset");

  // register port behaviour
  a_rd_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !rd_en |=> rdata_q == 8'h00)
    else $error("read data not zero when idle");
  a_rd_view: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == osc_pkg::REG_ADDR |=> rdata_q == $past(reg_view))
    else $error("control readback wrong");
  a_rd_cfg: assert property (@(posedge sys_clk) disable iff (reset)
    rd_en && addr == osc_pkg::ADDR_CFG
      |=> rdata_q == {4'h0, $past(cfg_multiplier_force), $past(cfg_osc_source_sel)})
    else $error("configuration view wrong");
  a_wr_other: assert property (@(posedge sys_clk) disable iff (reset)
    wr_en && addr != osc_pkg::REG_ADDR |=> $stable(reg_view))
    else $error("write to other address changed control");
  a_wr_fields: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr |=> int_osc_freq_sel_q == $past(wdata[osc_pkg::FREQ_HI:osc_pkg::FREQ_LO])
           && sys_clk_source_sel_q == $past(wdata[osc_pkg::SRC_HI:osc_pkg::SRC_LO])
           && sw_multiplier_enable_q == $past(wdata[osc_pkg::BIT_SW_MULT]))
    else $error("control fields not written");

  // source decode from the held select field, and the configuration mode copy
  a_src_sel3: assert property (@(posedge sys_clk) disable iff (reset)
    sys_clk_source_sel_q == 2'h3 |=> src_q == osc_pkg::OSC_SRC_INT)
    else $error("select 11 not internal");
  a_src_sel2: assert property (@(posedge sys_clk) disable iff (reset)
    sys_clk_source_sel_q == 2'h2 |=> src_q == osc_pkg::OSC_SRC_INT)
    else $error("select 10 not internal");
  a_src_hold: assert property (@(posedge sys_clk) disable iff (reset)
    $stable(sys_clk_source_sel_q) |=> $stable(src_q))
    else $error("source moved without select change");
  a_cfg_mode: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> cfg_mode_q == $past(cfg_osc_source_sel))
    else $error("configuration mode copy wrong");

  // band and rate for codes the earlier checks leave open
  a_band_mf: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q[3:2] == 2'h1 && $stable(int_osc_freq_sel_q)
      |=> band_q == osc_pkg::OSC_BAND_MF)
    else $error("mid code not in mid band");
  a_band_dup: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'h3 && $stable(int_osc_freq_sel_q)
      |=> band_q == osc_pkg::OSC_BAND_HF && khz_q == 16'h001F)
    else $error("code 0011 not high band duplicate");
  a_code_7: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'h7 && $stable(int_osc_freq_sel_q)
      |=> band_q == osc_pkg::OSC_BAND_MF && khz_q == 16'h01F4)
    else $error("code 0111 rate wrong");
  a_code_b: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'hB && $stable(int_osc_freq_sel_q)
      |=> khz_q == 16'h03E8)
    else $error("code 1011 rate wrong");
  a_code_8: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'h8 && $stable(int_osc_freq_sel_q)
      |=> khz_q == 16'h007D)
    else $error("code 1000 rate wrong");
  a_code_5: assert property (@(posedge sys_clk) disable iff (reset)
    int_osc_freq_sel_q == 4'h5 && $stable(int_osc_freq_sel_q)
      |=> khz_q == 16'h007D)
    else $error("code 0101 rate wrong");
  a_band_hold: assert property (@(posedge sys_clk) disable iff (reset)
    $stable(int_osc_freq_sel_q) && $stable(mult_d) |=> $stable(khz_q) && $stable(band_q))
    else $error("rate moved without code change");

  c_force_on: cover property (@(posedge sys_clk) disable iff (reset)
    cfg_multiplier_force && !sw_multiplier_enable_q ##1 times_four_multiplier_q);
  c_band_lf: cover property (@(posedge sys_clk) disable iff (reset)
    band_q == osc_pkg::OSC_BAND_LF);

  c_write_read: cover property (@(posedge sys_clk) disable iff (reset)
    reg_wr ##1 rd_en && addr == osc_pkg::REG_ADDR);
  c_mult_32m: cover property (@(posedge sys_clk) disable iff (reset)
    khz_q == 16'h7D00);
  c_src_timer: cover property (@(posedge sys_clk) disable iff (reset)
    src_q == osc_pkg::OSC_SRC_TIMER);
endmodule : osc_select_ctrl

// ==== sim/oscillator_select_control_tb_top.sv ====
// Purpose: self-checking bench for the oscillator select control block
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes:   fractional rates are expected truncated to whole kHz
module oscillator_select_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk = 1'b0;
  logic                reset   = 1'b1;
  logic [1:0]          addr    = 2'h0;
  logic [7:0]          wdata   = 8'h00;
  logic                wr_en   = 1'b0;
  logic                rd_en   = 1'b0;
  logic [7:0]          rdata_q;
  logic                force_in = 1'b0;
  logic [2:0]          cfg_sel  = 3'h0;
  logic                mult_q;
  osc_pkg::osc_src_t   src_q;
  logic [2:0]          cfg_mode_q;
  osc_pkg::osc_band_t  band_q;
  logic [15:0]         khz_q;
  int                  n_fail = 0;
  int                  cmp_count = 0;
  logic [7:0]          w;
  logic [7:0]          d;
  logic [7:0]          corner [4] = '{8'hF1, 8'h04, 8'h7E, 8'hFF};
  osc_select_ctrl i_osc_select_ctrl (.sys_clk(sys_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .cfg_multiplier_force(force_in), .cfg_osc_source_sel(cfg_sel),
    .times_four_multiplier_q(mult_q), .src_q(src_q), .cfg_mode_q(cfg_mode_q),
    .band_q(band_q), .khz_q(khz_q));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic wr(logic [1:0] a, logic [7:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1; addr <= a; wdata <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : wr
  task automatic rd(logic [1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    rd_en <= 1'b1; addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rdata_q;
  endtask : rd
  function automatic logic [2:0] exp_band(logic [3:0] c);
    if (c[3] || c == 4'h3) return osc_pkg::OSC_BAND_HF;
    return (c[3:1] == 3'h0) ? osc_pkg::OSC_BAND_LF : osc_pkg::OSC_BAND_MF;
  endfunction : exp_band
  function automatic logic [15:0] exp_khz(logic [3:0] c, logic m);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return 16'h001F;
      4'h4:    return 16'h003E;
      4'h5:    return 16'h007D;
      4'h6:    return 16'h00FA;
      4'h7:    return 16'h01F4;
      4'h8:    return 16'h007D;
      4'h9:    return 16'h00FA;
      4'hA:    return 16'h01F4;
      4'hB:    return 16'h03E8;
      4'hC:    return 16'h07D0;
      4'hD:    return 16'h0FA0;
      4'hE:    return m ? 16'h7D00 : 16'h1F40;
      default: return 16'h3E80;
    endcase
  endfunction : exp_khz
  task automatic check_outputs(logic [7:0] v);
    logic m;
    m = force_in | v[7];
    rd(2'h0, d);
    chk("ctrl readback", d, v & 8'hFB);
    @(posedge sys_clk);
    #1 chk("rdata idle", rdata_q, 8'h00);
    chk("multiplier", mult_q, m);
    chk("source", src_q, v[1] ? osc_pkg::OSC_SRC_INT : v[0] ? osc_pkg::OSC_SRC_TIMER
      : osc_pkg::OSC_SRC_CFG);
    chk("cfg mode", cfg_mode_q, cfg_sel);
    chk("band", band_q, exp_band(v[6:3]));
    chk("khz", khz_q, exp_khz(v[6:3], m));
  endtask : check_outputs
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hc811));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check_outputs(8'h38);
    wr(2'h1, 8'hFF);
    check_outputs(8'h38);
    rd(2'h2, d);
    chk("unmapped read", d, 8'h00);
    for (int i = 0; i < 44; i++) begin
      w = (i < 4) ? corner[i] : 8'($urandom);
      @(posedge sys_clk);
      force_in <= 1'($urandom);
      cfg_sel <= 3'($urandom);
      wr(2'h0, w);
      check_outputs(w);
    end
    rd(2'h1, d);
    chk("config view", d, {4'h0, force_in, cfg_sel});
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check_outputs(8'h38);
    finish_test();
  end
endmodule : oscillator_select_control_tb_top
